// >>> ssp_pkg.sv
// Shared constants and the state type of the synchronous serial port in SPI mode.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one clock domain.
package ssp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets.
	localparam logic [3:0] OFS_BUFFER  = 4'h0;
	localparam logic [3:0] OFS_CONTROL = 4'h4;
	localparam logic [3:0] OFS_STATUS  = 4'h8;
	localparam logic [3:0] OFS_AUX     = 4'hc;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int CTL_WRITE_COLLISION    = 7;
	localparam int CTL_OVF     = 6;
	localparam int CTL_EN      = 5;
	localparam int CTL_CKP     = 4;
	localparam int STS_SMP     = 7;
	localparam int STS_CKE     = 6;
	localparam int AUX_IRQ     = 0;
	localparam int AUX_IRQ_EN  = 1;
	localparam int AUX_DIR_SDO = 2;
	localparam int AUX_DIR_SCK = 3;
	localparam int AUX_DIR_SS  = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic       DIR_RESET     = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// Port mode codes.
	localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
	localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
	localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
	localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
	localparam logic [3:0] MODE_SLAVE_SS     = 4'h4;
	localparam logic [3:0] MODE_SLAVE_NOSS   = 4'h5;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: serial clock period in system clocks, and the half period derived from it.
	localparam int         SCK_DIV_FAST = 4;
	localparam int         SCK_DIV_MID  = 16;
	localparam int         SCK_DIV_SLOW = 64;
	localparam logic [5:0] HALF_FAST    = 6'(SCK_DIV_FAST / 2);
	localparam logic [5:0] HALF_MID     = 6'(SCK_DIV_MID / 2);
	localparam logic [5:0] HALF_SLOW    = 6'(SCK_DIV_SLOW / 2);
	localparam logic [3:0] LAST_HALF    = 4'hf;
	localparam logic [2:0] LAST_BIT     = 3'h7;

	typedef struct packed {
		logic       waitreq;
		logic [7:0] rdata;
		logic [7:0] buffer;
		logic [7:0] shift;
		logic [7:0] control;
		logic       sample_phase;
		logic       cke;
		logic       bf;
		logic       irq;
		logic       irq_en;
		logic       dir_sdo;
		logic       dir_sck;
		logic       dir_ss;
		logic       busy;
		logic [3:0] half;
		logic [5:0] div;
		logic       samp;
		logic [2:0] bits;
		logic       pend;
		logic       sck_prev;
		logic       sdo;
		logic       sdo_oe_n;
		logic       sck;
		logic       sck_oe_n;
		logic       wake;
	} ssp_state_type;

	localparam ssp_state_type STATE_RESET = '{waitreq: 1'b1, control: CONTROL_RESET,
		dir_sdo: DIR_RESET, dir_sck: DIR_RESET, dir_ss: DIR_RESET,
		sdo_oe_n: 1'b1, sck_oe_n: 1'b1, default: '0};

endpackage : ssp_pkg

// >>> ssp_sync_if.sv
// Carries raw pin levels into the synchroniser and the synchronised levels back.
// Assumes the raw side is asynchronous to the system clock.
`timescale 1ns/1ps
interface ssp_sync_if #(parameter int W = 3);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface : ssp_sync_if

// >>> ssp_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level; no word coherency is given.
`timescale 1ns/1ps
module ssp_sync #(
	parameter int W = 3
) (
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	ssp_sync_if.sync  port
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] hold;
	} ssp_sync_state_type;

	ssp_sync_state_type st;
	ssp_sync_state_type next_st;

	always_comb begin
		next_st.meta = port.raw;
		next_st.hold = st.meta;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign port.synced = st.hold;
endmodule : ssp_sync

// >>> ssp_spi.sv
// SPI-mode synchronous serial port: Avalon-MM registers, master clock generator and
// slave shifter sampling the external clock.
// Assumes pins arrive asynchronously, i_sleep and i_aux_tick come from logic on i_sys_clk.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps

// Summary of operation
// RL1: Pins are driven as serial pins only while port_enable is set.
// RL2: Software reconfigures by clearing port_enable, rewriting control, then setting it.
// RL3: Data in is automatic; data out, clock, select obey their direction bits.
// RL4: Shift out on the programmed edge, capture on the other; full duplex.
// RL5: Master starts clocking a byte as soon as the buffer is written.
// RL6: Master with data output disabled keeps receiving bytes into the buffer normally.
// RL7: Bytes are eight bits, MSB first; clock idles at clock_idle_polarity.
// RL8: Master clock is system clock over 4, 16, 64, or timer over 2.
// RL9: With clock_edge_select set, output data is valid before the first edge.
// RL10: Slave shifts on external clock edges and flags after the last bit.
// RL11: Clock line must already idle at the selected level before slave enable.
// RL12: Slave keeps working in sleep and wakes the system on a byte.
// RL13: Mode 04h enables transfer and data output only while select is low.
// RL14: Select rising releases the data output at once, even mid-byte.
// RL15: Select high in mode 0100, or enable cleared, resets the bit counter.
// RL16: Software must use select control for slave mode with clock_edge_select set.
// RL17: Master transfers freeze during sleep and resume afterwards.
// RL18: An enabled flag wakes the system when a slave byte completes.
// RL19: Slave shifter follows the external clock; eight bits set the flag.
// RL20: System reset disables the port and aborts any transfer.
// RL21: SPI modes 00,01,10,11 map to polarity/edge 0/1, 0/0, 1/1, 1/0.
// RL22: buffer_full sets on receive into the buffer, clears on buffer read.
// RL23: Buffer writes during shifting are ignored and set write_collision.
// RL24: Mode codes 0-3 select master rates, 4 and 5 slave variants.
// RL25: Master samples at end of output time if sample_phase, else middle.
// RL26: Slave without select counts edges from enable; every eighth bit ends a byte.
module ssp_spi (
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_sck,
	input  wire logic        i_sdi,
	input  wire logic        i_ss_n,
	input  wire logic        i_sleep,
	input  wire logic        i_aux_tick,
	output logic             o_sck,
	output logic             o_sck_oe_n,
	output logic             o_sdo,
	output logic             o_sdo_oe_n,
	output logic             o_wake
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation.
	ssp_sync_if #(.W(3)) pin_sync ();

	assign pin_sync.raw = {i_sck, i_sdi, i_ss_n};

	ssp_sync #(.W(3)) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.port      (pin_sync.sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decodes.
	ssp_pkg::ssp_state_type st;
	ssp_pkg::ssp_state_type next_st;

	logic       sck_s;
	logic       sdi_s;
	logic       ss_n_s;
	logic       en;
	logic       clock_idle_polarity;
	logic [3:0] mode;
	logic       is_master;
	logic       is_slave_ss;
	logic       is_slave;
	logic       ss_sel;
	logic       ss_reset;
	logic       slv_sck;
	logic       lead_edge;
	logic       trail_edge;
	logic       samp_edge;
	logic       shift_edge;
	logic [5:0] half_len;
	logic       half_end;
	logic       bus_req;
	logic       wr_acc;
	logic       rd_acc;
	logic [7:0] wdata;
	logic       wr_buf;
	logic       xfer_active;
	logic       start_xfer;
	logic [7:0] status_view;
	logic [7:0] aux_view;
	logic [7:0] rx_byte;
	logic       done;
	logic       bit_in;

	assign sck_s       = pin_sync.synced[2];
	assign sdi_s       = pin_sync.synced[1];
	assign ss_n_s      = pin_sync.synced[0];
	assign en          = st.control[ssp_pkg::CTL_EN];
	assign clock_idle_polarity         = st.control[ssp_pkg::CTL_CKP];
	assign mode        = st.control[3:0];
	assign is_master   = (mode <= ssp_pkg::MODE_MASTER_TIMER); // RL24
	assign is_slave_ss = (mode == ssp_pkg::MODE_SLAVE_SS);
	assign is_slave    = is_slave_ss || (mode == ssp_pkg::MODE_SLAVE_NOSS);
	// A select pin set as output drops its select function and reads as selected.
	assign ss_sel      = !is_slave_ss || !st.dir_ss || !ss_n_s; // RL3 RL13
	assign ss_reset    = is_slave_ss && st.dir_ss && ss_n_s;
	// A clock pin set as output in slave mode gives no edges.
	assign slv_sck     = st.dir_sck ? sck_s : clock_idle_polarity; // RL3 RL19
	assign lead_edge   = (slv_sck != st.sck_prev) && (slv_sck != clock_idle_polarity);
	assign trail_edge  = (slv_sck != st.sck_prev) && (slv_sck == clock_idle_polarity);
	assign samp_edge   = st.cke ? lead_edge : trail_edge; // RL4 RL21
	assign shift_edge  = st.cke ? trail_edge : lead_edge; // RL4 RL21
	assign half_len    = (mode == ssp_pkg::MODE_MASTER_DIV16) ? ssp_pkg::HALF_MID :
	                     (mode == ssp_pkg::MODE_MASTER_DIV64) ? ssp_pkg::HALF_SLOW :
	                     ssp_pkg::HALF_FAST; // RL8
	assign half_end    = st.busy && en && !i_sleep && // RL17
	                     ((mode == ssp_pkg::MODE_MASTER_TIMER) ? i_aux_tick :
	                      (st.div == half_len - 6'h01)); // RL8
	assign bus_req     = i_avs_read || i_avs_write;
	assign wr_acc      = i_avs_write && !st.waitreq && i_avs_byteenable[0];
	assign rd_acc      = i_avs_read && !st.waitreq;
	assign wdata       = i_avs_writedata[7:0];
	assign wr_buf      = wr_acc && (i_avs_address == ssp_pkg::OFS_BUFFER);
	assign xfer_active = st.busy || st.pend || (st.bits != 3'h0);
	assign start_xfer  = wr_buf && !xfer_active && en && is_master;
	assign status_view = {st.sample_phase, st.cke, 5'h00, st.bf};
	assign aux_view    = {1'b0, st.busy, sck_s, st.dir_ss, st.dir_sck, st.dir_sdo,
	                      st.irq_en, st.irq};

	////////////////////////////////////////////////////////////////////////////////
	// Next state. Software clears come first so that hardware sets win.
	always_comb begin
		next_st = st;
		rx_byte = 8'h00;
		done    = 1'b0;
		bit_in  = 1'b0;

		// One wait state: a request is seen with waitrequest high and taken next edge.
		next_st.waitreq = !(bus_req && st.waitreq);
		if (bus_req && st.waitreq) begin
			unique case (i_avs_address)
				ssp_pkg::OFS_BUFFER:  next_st.rdata = st.buffer;
				ssp_pkg::OFS_CONTROL: next_st.rdata = st.control;
				ssp_pkg::OFS_STATUS:  next_st.rdata = status_view;
				ssp_pkg::OFS_AUX:     next_st.rdata = aux_view;
				default:              next_st.rdata = 8'h00;
			endcase
		end
		if (wr_acc) begin
			unique case (i_avs_address)
				ssp_pkg::OFS_BUFFER: begin
					if (xfer_active) begin
						next_st.control[ssp_pkg::CTL_WRITE_COLLISION] = 1'b1; // RL23
					end else begin
						next_st.buffer = wdata;
						next_st.shift  = wdata; // RL9
					end
				end
				ssp_pkg::OFS_CONTROL: next_st.control = wdata;
				ssp_pkg::OFS_STATUS: begin
					next_st.sample_phase = wdata[ssp_pkg::STS_SMP];
					next_st.cke = wdata[ssp_pkg::STS_CKE];
				end
				ssp_pkg::OFS_AUX: begin
					next_st.irq     = wdata[ssp_pkg::AUX_IRQ];
					next_st.irq_en  = wdata[ssp_pkg::AUX_IRQ_EN];
					next_st.dir_sdo = wdata[ssp_pkg::AUX_DIR_SDO];
					next_st.dir_sck = wdata[ssp_pkg::AUX_DIR_SCK];
					next_st.dir_ss  = wdata[ssp_pkg::AUX_DIR_SS];
				end
				default: begin
				end
			endcase
		end
		if (start_xfer) begin
			next_st.busy = 1'b1; // RL5
			next_st.half = 4'h0;
			next_st.div  = 6'h00;
		end
		if (rd_acc && (i_avs_address == ssp_pkg::OFS_BUFFER)) begin
			next_st.bf = 1'b0; // RL22
		end

		// Master: sixteen half periods per byte; odd halves end with a shift.
		if (half_end) begin
			next_st.div = 6'h00;
			if (!st.half[0]) begin
				next_st.samp = sdi_s; // RL25
			end else begin
				bit_in        = st.sample_phase ? sdi_s : st.samp; // RL25
				next_st.shift = {st.shift[6:0], bit_in}; // RL4 RL6 RL7
				if (st.half == ssp_pkg::LAST_HALF) begin
					next_st.busy = 1'b0;
					rx_byte      = {st.shift[6:0], bit_in};
					done         = 1'b1;
				end
			end
			next_st.half = st.half + 4'h1;
		end else if (st.busy && !i_sleep) begin
			next_st.div = st.div + 6'h01; // RL17
		end

		// Slave: runs in sleep too, since only the external clock moves it.
		if (en && is_slave && ss_sel) begin
			if (samp_edge) begin
				if (st.bits == ssp_pkg::LAST_BIT) begin
					rx_byte       = {st.shift[6:0], sdi_s}; // RL10 RL19 RL26
					next_st.shift = rx_byte;
					next_st.bits  = 3'h0;
					next_st.pend  = 1'b0;
					done          = 1'b1;
				end else begin
					next_st.samp = sdi_s; // RL4
					next_st.pend = 1'b1;
					next_st.bits = st.bits + 3'h1;
				end
			end else if (shift_edge && st.pend) begin
				next_st.shift = {st.shift[6:0], st.samp}; // RL4 RL7
				next_st.pend  = 1'b0;
			end
		end

		if (done) begin
			next_st.irq = 1'b1; // RL10 RL12 RL18 RL19
			if (st.bf && !is_master) begin
				next_st.control[ssp_pkg::CTL_OVF] = 1'b1;
			end else begin
				next_st.buffer = rx_byte; // RL6 RL22
				next_st.bf     = 1'b1; // RL22
			end
		end

		if (!en || ss_reset) begin
			next_st.bits = 3'h0; // RL15
			next_st.pend = 1'b0; // RL15
			if (!en) begin
				next_st.busy = 1'b0; // RL15
				next_st.half = 4'h0;
				next_st.div  = 6'h00;
			end
		end

		// Pins.
		next_st.sck_prev = slv_sck;
		next_st.sdo      = next_st.shift[7]; // RL7 RL9
		next_st.sdo_oe_n = !(en && (is_master || is_slave) && !st.dir_sdo && ss_sel); // RL1 RL3 RL13 RL14
		next_st.sck_oe_n = !(en && is_master && !st.dir_sck); // RL1 RL3
		next_st.sck      = clock_idle_polarity ^ (en && is_master && next_st.busy &&
		                   (next_st.half[0] == st.cke)); // RL7 RL21
		next_st.wake     = i_sleep && st.irq_en && next_st.irq; // RL12 RL18
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= ssp_pkg::STATE_RESET; // RL20
		end else begin
			st <= next_st;
		end
	end

	assign o_avs_readdata    = {24'h000000, st.rdata};
	assign o_avs_waitrequest = st.waitreq;
	assign o_sck             = st.sck;
	assign o_sck_oe_n        = st.sck_oe_n;
	assign o_sdo             = st.sdo;
	assign o_sdo_oe_n        = st.sdo_oe_n;
	assign o_wake            = st.wake;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);

	sequence s_fast_start;
		$rose(st.busy) && (mode == ssp_pkg::MODE_MASTER_DIV4) ##0 (!i_sleep && en)[*2];
	endsequence

	sequence s_sel_high;
		en && ss_reset;
	endsequence

	property p_pins_off;
		!en |=> (o_sdo_oe_n && o_sck_oe_n);
	endproperty
	a_pins_off: assert property (p_pins_off) else $error("pins driven while disabled"); // RL1

	property p_start;
		start_xfer |=> (st.busy && (st.half == 4'h0) && (st.shift == $past(wdata)));
	endproperty
	a_start: assert property (p_start) else $error("master did not start"); // RL5

	property p_fast_rate;
		s_fast_start |=> (st.half == 4'h1);
	endproperty
	a_fast_rate: assert property (p_fast_rate) else $error("fast clock half wrong"); // RL8

	property p_idle_level;
		(en && is_master && !st.busy && !start_xfer) |=> (o_sck == $past(clock_idle_polarity));
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("clock not idle"); // RL7

	property p_collision;
		(wr_buf && xfer_active) |=> (st.control[ssp_pkg::CTL_WRITE_COLLISION] && $stable(st.buffer));
	endproperty
	a_collision: assert property (p_collision) else $error("collision missed"); // RL23

	property p_master_done;
		(half_end && (st.half == ssp_pkg::LAST_HALF)) |=> (st.bf && st.irq && !st.busy);
	endproperty
	a_master_done: assert property (p_master_done) else $error("byte end wrong"); // RL22

	property p_sel_reset;
		s_sel_high |=> ((st.bits == 3'h0) && !st.pend);
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("counter not reset"); // RL15

	property p_sel_release;
		s_sel_high |=> o_sdo_oe_n;
	endproperty
	a_sel_release: assert property (p_sel_release) else $error("data out still driven"); // RL14

	property p_sleep_freeze;
		(st.busy && en && i_sleep) |=> ($stable(st.half) && $stable(st.div) && st.busy);
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze) else $error("master moved in sleep"); // RL17
endmodule : ssp_spi

// >>> ssp_far_end.sv
// Far-end SPI peer: a slave that answers the device's clock, or a master that clocks it.
// Assumes the bench resolves the shared wires and keeps cpol and cpha steady within a frame.
`timescale 1ns/1ps
module ssp_far_end #(
	parameter int HALF = 8
) (
	input  wire logic i_clk,
	input  wire logic i_cpol,
	input  wire logic i_cpha,
	input  wire logic i_sck,
	input  wire logic i_miso,
	output logic      o_mosi,
	output logic      o_sck,
	output logic      o_ss_n
);
	logic [7:0] tx_sh = 8'h00;
	logic [7:0] rx_sh = 8'h00;
	logic       slv_on = 1'b0;
	logic       mst_on = 1'b0;

	initial begin
		o_mosi = 1'b0;
		o_sck = 1'b0;
		o_ss_n = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outside frames the clock stands still at its idle level, so a slave enable sees no edge.
	always @(posedge i_clk) begin
		if (!mst_on) begin
			o_sck <= i_cpol;
		end
	end

	// Slave role: sample on the leading edge when cpha is 0, on the trailing edge otherwise.
	always @(i_sck) begin
		if (slv_on) begin
			if ((i_sck != i_cpol) ^ i_cpha) begin
				rx_sh = {rx_sh[6:0], i_miso};
			end else if (i_cpha) begin
				o_mosi <= tx_sh[7];
				tx_sh = tx_sh << 1;
			end else begin
				o_mosi <= tx_sh[6];
				tx_sh = tx_sh << 1;
			end
		end
	end

	task automatic arm(input logic [7:0] d);
		tx_sh = d;
		rx_sh = 8'h00;
		o_mosi <= d[7];
		slv_on = 1'b1;
	endtask : arm

	////////////////////////////////////////////////////////////////////////////////
	// Master role: a frame of nb bits; a short frame models an aborted byte.
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		logic [7:0] s;
		s = tx;
		rx = 8'h00;
		slv_on = 1'b0;
		mst_on = 1'b1;
		o_ss_n <= 1'b0;
		o_mosi <= s[7];
		repeat (HALF) @(posedge i_clk);
		for (int i = 0; i < nb; i++) begin
			o_sck <= !i_cpol;
			if (i_cpha) begin
				o_mosi <= s[7];
				s = s << 1;
			end else begin
				rx = {rx[6:0], i_miso};
			end
			repeat (HALF) @(posedge i_clk);
			o_sck <= i_cpol;
			if (i_cpha) begin
				rx = {rx[6:0], i_miso};
			end else begin
				o_mosi <= s[6];
				s = s << 1;
			end
			repeat (HALF) @(posedge i_clk);
		end
		o_ss_n <= 1'b1;
		o_mosi <= !o_mosi;
		mst_on = 1'b0;
	endtask : xfer
endmodule : ssp_far_end

// >>> ssp_spi_tb_top.sv
// Self-checking bench for the SPI-mode serial port: register bus, master and slave frames.
// Assumes the far-end model drives the link and a byte queue holds the expected receptions.
`timescale 1ns/1ps
module ssp_spi_tb_top;
	localparam int TICK_GAP = 5;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        waitreq;
	logic        sleep = 1'b0;
	logic        aux_tick = 1'b0;
	logic        p_cpol = 1'b0;
	logic        p_cpha = 1'b0;
	logic        p_mosi, p_sck, p_ss_n, flt = 1'b0, sck_q = 1'b0;
	logic        dut_sck, dut_sck_oe_n, dut_sdo, dut_sdo_oe_n, dut_wake;
	wire logic   sck_wire = dut_sck_oe_n ? p_sck : dut_sck;
	wire logic   miso_wire = dut_sdo_oe_n ? flt : dut_sdo;
	int          mismatches = 0, cmp_count = 0, tick_cnt = 0, cyc = 0, tog = 0, t0 = 0, t1 = 0;
	logic [7:0]  exp_q [$];
	int          halves [4] = '{int'(ssp_pkg::HALF_FAST), int'(ssp_pkg::HALF_MID),
		int'(ssp_pkg::HALF_SLOW), TICK_GAP};

	always #4 clk = !clk;

	// A released data line shows the inverse of the last value the port drove on it.
	always @(posedge clk) begin
		if (!dut_sdo_oe_n) flt <= !dut_sdo;
		cyc <= cyc + 1;
		tick_cnt <= (tick_cnt == TICK_GAP - 1) ? 0 : tick_cnt + 1;
		aux_tick <= (tick_cnt == TICK_GAP - 1);
		sck_q <= dut_sck;
		if (dut_sck !== sck_q && !dut_sck_oe_n) begin
			tog <= tog + 1;
			// The span starts at the second toggle, since a timer-paced first half starts off-tick.
			if (tog == 1) t0 <= cyc;
			t1 <= cyc;
		end
	end

	ssp_spi i_dut (.i_sys_clk(clk), .i_resetn(rst_n), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.i_avs_byteenable(4'h1), .o_avs_readdata(avs_readdata), .o_avs_waitrequest(waitreq),
		.i_sck(sck_wire), .i_sdi(p_mosi), .i_ss_n(p_ss_n), .i_sleep(sleep),
		.i_aux_tick(aux_tick), .o_sck(dut_sck), .o_sck_oe_n(dut_sck_oe_n), .o_sdo(dut_sdo),
		.o_sdo_oe_n(dut_sdo_oe_n), .o_wake(dut_wake));

	ssp_far_end #(.HALF(8)) i_far (.i_clk(clk), .i_cpol(p_cpol), .i_cpha(p_cpha),
		.i_sck(sck_wire), .i_miso(miso_wire), .o_mosi(p_mosi), .o_sck(p_sck), .o_ss_n(p_ss_n));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_pin(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_pin

	// One Avalon cycle: held until waitrequest is seen low, then released after that edge.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n = 0;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		chk_pin("waitrequest", 1'b0, waitreq);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic setup(input logic [3:0] mode, input logic cpol, input logic cke,
		input logic sample_phase);
		logic [7:0] q;
		bus(1'b1, ssp_pkg::OFS_CONTROL, 8'h00, q);
		repeat (2) @(posedge clk);
		chk_pin("sck oe", 1'b1, dut_sck_oe_n);
		chk_pin("sdo oe", 1'b1, dut_sdo_oe_n);
		bus(1'b1, ssp_pkg::OFS_STATUS, {sample_phase, cke, 6'h3f}, q);
		bus(1'b1, ssp_pkg::OFS_CONTROL, {3'b001, cpol, mode}, q);
	endtask : setup

	task automatic regs_check(input string name);
		logic [3:0] adr [4] = '{ssp_pkg::OFS_CONTROL, ssp_pkg::OFS_STATUS, ssp_pkg::OFS_AUX, 4'h2};
		logic [7:0] val [4] = '{8'h00, 8'h00, 8'h1c, 8'h00};
		logic [7:0] q;
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, adr[k], 8'h00, q);
			chk("register", val[k], q);
		end
		$display("test %s done", name);
	endtask : regs_check

	////////////////////////////////////////////////////////////////////////////////
	// Master byte at each rate, one standard SPI mode per rate; rate 3 runs with SDO off.
	task automatic master_byte(input int i);
		logic [7:0] tx, sb, q;
		logic       cpol, cke;
		int         n = 0;
		tx = 8'($urandom);
		sb = 8'($urandom);
		cpol = i[1];
		cke = !i[0];
		p_cpol <= cpol;
		p_cpha <= !cke;
		setup(4'(i), cpol, cke, i == 0);
		bus(1'b1, ssp_pkg::OFS_AUX, (i == 3) ? 8'h14 : 8'h10, q);
		i_far.arm(sb);
		exp_q.push_back(sb);
		tog <= 0;
		bus(1'b1, ssp_pkg::OFS_BUFFER, tx, q);
		bus(1'b1, ssp_pkg::OFS_BUFFER, ~tx, q);
		q = 8'h00;
		while (q[0] !== 1'b1 && n < 300) begin
			bus(1'b0, ssp_pkg::OFS_STATUS, 8'h00, q);
			n++;
		end
		bus(1'b0, ssp_pkg::OFS_CONTROL, 8'h00, q);
		chk("control", {3'b101, cpol, 4'(i)}, q);
		bus(1'b0, ssp_pkg::OFS_BUFFER, 8'h00, q);
		chk("rx byte", exp_q.pop_front(), q);
		bus(1'b0, ssp_pkg::OFS_STATUS, 8'h00, q);
		chk("status", {i == 0, cke, 6'h00}, q);
		chk("toggles", 32'd16, tog);
		chk("span", 32'(14 * halves[i]), 32'(t1 - t0));
		chk_pin("sck idle", cpol, dut_sck);
		chk_pin("sdo oe", i == 3, dut_sdo_oe_n);
		if (i != 3) chk("far rx", tx, i_far.rx_sh);
		$display("test master %0d done", i);
	endtask : master_byte

	// Slave byte clocked by the far end; in select mode a short frame is aborted first.
	task automatic slave_byte(input logic [3:0] mode, input logic cpol, input logic cke);
		logic [7:0] d, m, r, q;
		d = 8'($urandom);
		m = 8'($urandom);
		p_cpol <= cpol;
		p_cpha <= !cke;
		bus(1'b1, ssp_pkg::OFS_AUX, 8'h1a, q);
		repeat (4) @(posedge clk);
		bus(1'b0, ssp_pkg::OFS_AUX, 8'h00, q);
		chk_pin("sck level", cpol, q[5]);
		setup(mode, cpol, cke, 1'b0);
		bus(1'b1, ssp_pkg::OFS_AUX, 8'h1a, q);
		if (mode == ssp_pkg::MODE_SLAVE_SS) begin
			bus(1'b1, ssp_pkg::OFS_BUFFER, ~d, q);
			i_far.xfer(m, 3, r);
			repeat (6) @(posedge clk);
			chk_pin("sdo release", 1'b1, dut_sdo_oe_n);
		end
		bus(1'b1, ssp_pkg::OFS_BUFFER, d, q);
		exp_q.push_back(m);
		i_far.xfer(m, 8, r);
		repeat (6) @(posedge clk);
		chk("far rx", d, r);
		chk_pin("wake", 1'b1, dut_wake);
		bus(1'b0, ssp_pkg::OFS_BUFFER, 8'h00, q);
		chk("rx byte", exp_q.pop_front(), q);
		bus(1'b1, ssp_pkg::OFS_AUX, 8'h1a, q);
		repeat (2) @(posedge clk);
		chk_pin("wake clear", 1'b0, dut_wake);
		$display("test slave %0d done", mode);
	endtask : slave_byte

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		stop_test();
	end

	initial begin
		logic [7:0] q;
		void'($urandom(3));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		regs_check("reset");
		bus(1'b1, ssp_pkg::OFS_STATUS, 8'hff, q);
		bus(1'b0, ssp_pkg::OFS_STATUS, 8'h00, q);
		chk("status ro", 8'hc0, q);
		for (int i = 0; i < 4; i++) master_byte(i);
		sleep <= 1'b1;
		slave_byte(ssp_pkg::MODE_SLAVE_SS, 1'b0, 1'b1);
		slave_byte(ssp_pkg::MODE_SLAVE_NOSS, 1'b1, 1'b0);
		sleep <= 1'b0;
		p_cpol <= 1'b0;
		setup(ssp_pkg::MODE_MASTER_DIV64, 1'b0, 1'b1, 1'b0);
		bus(1'b1, ssp_pkg::OFS_AUX, 8'h10, q);
		tog <= 0;
		bus(1'b1, ssp_pkg::OFS_BUFFER, 8'h5a, q);
		sleep <= 1'b1;
		repeat (40) @(posedge clk);
		chk("sleep toggles", 32'd0, tog);
		sleep <= 1'b0;
		repeat (40) @(posedge clk);
		chk("resume toggles", 32'd1, tog);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk_pin("reset sck oe", 1'b1, dut_sck_oe_n);
		rst_n <= 1'b1;
		@(posedge clk);
		regs_check("abort");
		stop_test();
	end
endmodule : ssp_spi_tb_top
